// ---- clm_cfg.svh ----
`ifndef CLM_CFG_SVH
`define CLM_CFG_SVH
// Register indices on the plain register port
`define CLM_A_STAT1 4'h0
`define CLM_A_STAT2 4'h1
`define CLM_A_CMD1 4'h2
`define CLM_A_CMD2 4'h3
`define CLM_A_CFG1 4'h4
`define CLM_A_CFG2 4'h5
`define CLM_A_LAT1L 4'h6
`define CLM_A_LAT1H 4'h7
`define CLM_A_LAT2L 4'h8
`define CLM_A_LAT2H 4'h9
`define CLM_A_MON1L 4'ha
`define CLM_A_MON1H 4'hb
`define CLM_A_MON2L 4'hc
`define CLM_A_MON2H 4'hd
`define CLM_A_TGT1L 4'he
`define CLM_A_TGT1H 4'hf
// Command word bits
`define CLM_CMD_START 0
`define CLM_CMD_SWRST 1
`define CLM_CMD_MEAS 2
`define CLM_CMD_DIR 3
`define CLM_CMD_LEN1 8
`define CLM_CMD_LEN2 9
// Status word bits
`define CLM_ST_MEASURING 6
`define CLM_ST_LATCHED 8
// Config word fields
`define CLM_CFG_FAST 0
`define CLM_CFG_MODE_LO 1
`define CLM_CFG_MODE_HI 2
`define CLM_CFG_ZRST 3
`define CLM_CFG_CIRC 4
`define CLM_CFG_RANGE 5
`define CLM_CFG_FREQ 6
// Rates and timing
`define CLM_CLK_HZ 40000000
`define CLM_SLOW_HZ 50000
`define CLM_FAST_HZ 500000
`define CLM_FREQ_MAX 32'h0007a120
`define CLM_SAMPLE_MS 1
`define CLM_RST_W16 16'h0000
`endif

// ---- clm_pkg.sv ----
package clm_pkg;
	typedef enum logic [1:0] {
		CLM_IN_QUAD = 2'h0,
		CLM_IN_UPDN = 2'h1,
		CLM_IN_PDIR = 2'h2
	} clm_inmode_t;
	// Encoder and latch pins of one counter
	typedef struct packed {
		logic pha;
		logic phb;
		logic phz;
		logic latch1;
		logic latch2;
	} clm_pins_t;
	// Per-counter configuration word fields
	typedef struct packed {
		logic freq_mode;
		logic range_cmp;
		logic circular;
		logic zrst;
		clm_inmode_t in_mode;
		logic fast;
	} clm_cfg_t;
endpackage

// ---- clm_latch_measure.sv ----
`timescale 1ns/1ps
`include "clm_cfg.svh"
module clm_latch_measure #(
	parameter int CW = 32,
	parameter int SAMPLE_CYC = `CLM_CLK_HZ / 1000 * `CLM_SAMPLE_MS,
	parameter int FREQ_CYC = `CLM_CLK_HZ
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Register port
	input wire logic [3:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [15:0] rdata,
	// Encoder and latch pins, two counters
	input clm_pkg::clm_pins_t pins [2],
	// Count check results
	output logic [1:0] target_hit,
	output logic [1:0] in_range,
	// Refresh tick for the latched flags
	input wire logic io_refresh
);
	localparam int SLOW_DIV = `CLM_CLK_HZ / `CLM_SLOW_HZ;
	localparam int FAST_DIV = `CLM_CLK_HZ / `CLM_FAST_HZ;

	logic [15:0] cmd_r [2];
	logic [15:0] cfg_r [2];
	logic [CW-1:0] cnt_r [2];
	logic [CW-1:0] latch_r [2];
	logic [CW-1:0] mon_r [2];
	logic [CW-1:0] prev_r [2];
	logic [CW-1:0] tgt_r;
	logic [CW-1:0] hi_r;
	logic [1:0] pend_r;
	logic [1:0] flag_r;
	logic [15:0] rdata_nxt;
	wire wr_cmd1 = wr && addr == `CLM_A_CMD1;
	wire wr_cmd2 = wr && addr == `CLM_A_CMD2;

	genvar g;
	generate
	for (g = 0; g < 2; g++) begin : gch
		clm_pkg::clm_cfg_t cfg;
		logic [4:0] pin_d_r;
		logic [15:0] gap_r;
		logic [31:0] samp_r;
		logic [31:0] edges_r;
		logic [31:0] fwin_r;
		logic meas_on;
		logic inc;
		logic dec;
		logic l1_rise;
		logic l2_rise;
		logic cap;
		logic z_clr;
		logic gap_ok;
		logic [CW-1:0] cnt_nxt;
		logic [CW-1:0] stepped;
		logic [15:0] gap_max;
		logic wr_this;
		logic clr_flag;
		assign cfg = clm_pkg::clm_cfg_t'(cfg_r[g][6:0]);
		assign wr_this = (g == 0) ? wr_cmd1 : wr_cmd2;
		// rate limit: edges closer than one period are dropped
		assign gap_max = cfg.fast ? 16'(FAST_DIV) : 16'(SLOW_DIV);
		assign gap_ok = gap_r >= gap_max;
		always_comb begin
			inc = 1'b0;
			dec = 1'b0;
			case (cfg.in_mode)
				clm_pkg::CLM_IN_QUAD: begin
					inc = pins[g].pha & ~pin_d_r[0] & ~pins[g].phb;
					dec = pins[g].pha & ~pin_d_r[0] & pins[g].phb;
				end
				clm_pkg::CLM_IN_UPDN: begin
					inc = pins[g].pha & ~pin_d_r[0];
					dec = pins[g].phb & ~pin_d_r[1];
				end
				clm_pkg::CLM_IN_PDIR: begin
					inc = pins[g].pha & ~pin_d_r[0] & ~pins[g].phb;
					dec = pins[g].pha & ~pin_d_r[0] & pins[g].phb;
				end
				default: begin
					inc = 1'b0;
					dec = 1'b0;
				end
			endcase
		end
		// circular wrap at the high limit, linear otherwise
		always_comb begin
			stepped = cnt_r[g];
			if (inc && gap_ok) begin
				if (cfg.circular && cnt_r[g] >= hi_r)
					stepped = '0;
				else
					stepped = cnt_r[g] + CW'(1);
			end else if (dec && gap_ok) begin
				if (cfg.circular && cnt_r[g] == '0)
					stepped = hi_r;
				else
					stepped = cnt_r[g] - CW'(1);
			end
		end
		// reset source: index with reset bit, or bit alone
		assign z_clr = cmd_r[g][`CLM_CMD_SWRST] &
			(cfg.zrst ? pins[g].phz : 1'b1);
		// counting only while start bit set
		assign cnt_nxt = z_clr ? '0 :
			(cmd_r[g][`CLM_CMD_START] ? stepped : cnt_r[g]);
		// latch two ignored while latch one enabled; disabled edges ignored
		assign l1_rise = pins[g].latch1 & ~pin_d_r[3];
		assign l2_rise = pins[g].latch2 & ~pin_d_r[4];
		assign cap = cmd_r[g][`CLM_CMD_LEN1] ? l1_rise :
			(cmd_r[g][`CLM_CMD_LEN2] & l2_rise);
		assign meas_on = cmd_r[g][`CLM_CMD_MEAS];
		// Software clears flag by writing bit 8 low in command word
		assign clr_flag = wr_this & ~wdata[`CLM_ST_LATCHED];
		always_ff @(posedge clock) begin
			if (rst) begin
				cnt_r[g] <= '0;
				pin_d_r <= '0;
				gap_r <= '1;
			end else begin
				cnt_r[g] <= cnt_nxt;
				pin_d_r <= {pins[g].latch2, pins[g].latch1, pins[g].phz,
					pins[g].phb, pins[g].pha};
				gap_r <= ((inc | dec) & gap_ok) ? 16'h0001 :
					(gap_ok ? gap_r : gap_r + 16'h0001);
			end
		end
		// single latch register, overwritten each capture
		always_ff @(posedge clock) begin
			if (rst)
				latch_r[g] <= '0;
			else if (cap)
				latch_r[g] <= cnt_r[g];
		end
		// flag set at refresh; set beats clear
		always_ff @(posedge clock) begin
			if (rst) begin
				pend_r[g] <= 1'b0;
				flag_r[g] <= 1'b0;
			end else begin
				pend_r[g] <= cap | (pend_r[g] & ~io_refresh);
				if (io_refresh & (pend_r[g] | cap))
					flag_r[g] <= 1'b1;
				else if (clr_flag)
					flag_r[g] <= 1'b0;
			end
		end
		always_ff @(posedge clock) begin
			if (rst || !meas_on) begin
				samp_r <= '0;
				fwin_r <= '0;
				edges_r <= '0;
				prev_r[g] <= cnt_r[g];
				if (rst)
					mon_r[g] <= '0;
			end else if (g == 0 && cfg.freq_mode) begin
				edges_r <= edges_r + 32'(((cmd_r[g][`CLM_CMD_DIR] ? dec
					: inc) & gap_ok) ? 1 : 0);
				if (fwin_r == 32'(FREQ_CYC - 1)) begin
					fwin_r <= '0;
					edges_r <= '0;
					mon_r[g] <= (edges_r > `CLM_FREQ_MAX) ?
						CW'(`CLM_FREQ_MAX) : CW'(edges_r);
				end else
					fwin_r <= fwin_r + 32'h1;
			end else begin
				if (samp_r == 32'(SAMPLE_CYC - 1)) begin
					samp_r <= '0;
					prev_r[g] <= cnt_r[g];
					mon_r[g] <= cnt_r[g] - prev_r[g];
				end else
					samp_r <= samp_r + 32'h1;
			end
		end
		// count check by target match or range
		always_ff @(posedge clock) begin
			if (rst) begin
				target_hit[g] <= 1'b0;
				in_range[g] <= 1'b0;
			end else begin
				target_hit[g] <= ~cfg.range_cmp &
					(cnt_nxt == tgt_r) & (cnt_r[g] != tgt_r);
				in_range[g] <= cfg.range_cmp &
					(cnt_r[g] >= tgt_r) & (cnt_r[g] <= hi_r);
			end
		end
	end
	endgenerate

	// Command and configuration registers; latched flag kept aside
	always_ff @(posedge clock) begin
		if (rst) begin
			cmd_r[0] <= `CLM_RST_W16;
			cmd_r[1] <= `CLM_RST_W16;
			cfg_r[0] <= `CLM_RST_W16;
			cfg_r[1] <= `CLM_RST_W16;
			tgt_r <= '0;
			hi_r <= '1;
		end else if (wr) begin
			case (addr)
				`CLM_A_CMD1: cmd_r[0] <= wdata;
				`CLM_A_CMD2: cmd_r[1] <= wdata;
				`CLM_A_CFG1: cfg_r[0] <= wdata;
				`CLM_A_CFG2: cfg_r[1] <= wdata & 16'hffbf;
				`CLM_A_TGT1L: tgt_r[15:0] <= wdata;
				`CLM_A_TGT1H: tgt_r[CW-1:16] <= wdata[CW-17:0];
				`CLM_A_LAT2L: hi_r[15:0] <= wdata;
				`CLM_A_LAT2H: hi_r[CW-1:16] <= wdata[CW-17:0];
				default: ;
			endcase
		end
	end

	// Status word: measuring and latched bits
	function automatic logic [15:0] stat_word(input logic meas,
		input logic lat);
		logic [15:0] s;
		s = '0;
		s[`CLM_ST_MEASURING] = meas;
		s[`CLM_ST_LATCHED] = lat;
		return s;
	endfunction

	// Read multiplexer; every index is mapped, high limit indices read back latch two
	always_comb begin
		rdata_nxt = '0;
		case (addr)
			`CLM_A_STAT1: rdata_nxt = stat_word(cmd_r[0][`CLM_CMD_MEAS],
				flag_r[0]);
			`CLM_A_STAT2: rdata_nxt = stat_word(cmd_r[1][`CLM_CMD_MEAS],
				flag_r[1]);
			`CLM_A_CMD1: rdata_nxt = cmd_r[0];
			`CLM_A_CMD2: rdata_nxt = cmd_r[1];
			`CLM_A_CFG1: rdata_nxt = cfg_r[0];
			`CLM_A_CFG2: rdata_nxt = cfg_r[1];
			`CLM_A_LAT1L: rdata_nxt = latch_r[0][15:0];
			`CLM_A_LAT1H: rdata_nxt = latch_r[0][31:16];
			`CLM_A_LAT2L: rdata_nxt = latch_r[1][15:0];
			`CLM_A_LAT2H: rdata_nxt = latch_r[1][31:16];
			`CLM_A_MON1L: rdata_nxt = mon_r[0][15:0];
			`CLM_A_MON1H: rdata_nxt = mon_r[0][31:16];
			`CLM_A_MON2L: rdata_nxt = mon_r[1][15:0];
			`CLM_A_MON2H: rdata_nxt = mon_r[1][31:16];
			`CLM_A_TGT1L: rdata_nxt = tgt_r[15:0];
			`CLM_A_TGT1H: rdata_nxt = tgt_r[31:16];
			default: rdata_nxt = '0;
		endcase
	end

	// Read data holds one cycle after the strobe only
	always_ff @(posedge clock) begin
		if (rst)
			rdata <= '0;
		else
			rdata <= rd ? rdata_nxt : '0;
	end
endmodule // clm_latch_measure

// ---- clm_enc_model.sv ----
`timescale 1ns/1ps
// Encoder and latch source for both counters
module clm_enc_model #(
	parameter int HALF = 40
) (
	// Clock
	input wire logic clock,
	// Pulse run requests, latch levels
	input wire logic [1:0] run,
	input wire logic [3:0] lat,
	// Pins and pulses sent so far
	output clm_pkg::clm_pins_t pins [2],
	output logic [15:0] sent [2]
);
	int t = 0;
	logic [1:0] up = 2'h0;
	initial sent = '{16'h0, 16'h0};
	// Whole pulses only, so the rate never exceeds the fast limit
	always @(posedge clock) begin
		t <= (t == 2 * HALF - 1) ? 0 : t + 1;
		for (int k = 0; k < 2; k++) begin
			if (t == 0)
				up[k] <= run[k];
			if (t == 0 && run[k])
				sent[k] <= sent[k] + 16'h1;
		end
	end
	// Up pulses on phase A; down and index held low
	always_comb begin
		for (int k = 0; k < 2; k++) begin
			pins[k].pha = up[k] && t < HALF;
			pins[k].phb = 1'b0;
			pins[k].phz = 1'b0;
			pins[k].latch1 = lat[2 * k];
			pins[k].latch2 = lat[2 * k + 1];
		end
	end
endmodule // clm_enc_model

// ---- clm_latch_measure_sva.sv ----
`timescale 1ns/1ps
// Port checks of the latch and measure block
module clm_latch_measure_chk (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Register port
	input wire logic [3:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [15:0] rdata,
	// Count check results
	input wire logic [1:0] target_hit,
	input wire logic [1:0] in_range
);
	default clocking @(posedge clock);
	endclocking
	default disable iff (rst);
	// Read data only answers a read
	property p_rd_quiet;
		!rd |=> rdata == 16'h0;
	endproperty
	// Register words read back what was written
	property p_cmd1_echo;
		wr && addr == 4'h2 ##1 rd && addr == 4'h2
		|=> rdata == $past(wdata, 2);
	endproperty
	property p_cmd2_echo;
		wr && addr == 4'h3 ##1 rd && addr == 4'h3
		|=> rdata == $past(wdata, 2);
	endproperty
	property p_cfg_echo;
		wr && addr == 4'h4 ##1 rd && addr == 4'h4
		|=> rdata[5:0] == $past(wdata[5:0], 2);
	endproperty
	// Match is a single pulse
	property p_hit0;
		target_hit[0] |=> !target_hit[0];
	endproperty
	property p_hit1;
		target_hit[1] |=> !target_hit[1];
	endproperty
	// Only one check method per counter
	property p_excl0;
		!(target_hit[0] && in_range[0]);
	endproperty
	property p_excl1;
		!(target_hit[1] && in_range[1]);
	endproperty
	a_rd_quiet: assert property (p_rd_quiet) else $error("stray rdata");
	a_cmd1_echo: assert property (p_cmd1_echo) else $error("cmd1");
	a_cmd2_echo: assert property (p_cmd2_echo) else $error("cmd2");
	a_cfg_echo: assert property (p_cfg_echo) else $error("cfg");
	a_hit0: assert property (p_hit0) else $error("hit0 long");
	a_hit1: assert property (p_hit1) else $error("hit1 long");
	a_excl0: assert property (p_excl0) else $error("both 0");
	a_excl1: assert property (p_excl1) else $error("both 1");
	c_read: cover property (rd ##1 rdata != 16'h0);
	c_hit0: cover property (target_hit[0]);
	c_echo: cover property (wr && addr == 4'h2 ##1 rd);
endmodule // clm_latch_measure_chk
bind clm_latch_measure clm_latch_measure_chk u_chk (.clock(clock),
	.rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
	.rdata(rdata), .target_hit(target_hit), .in_range(in_range));

// ---- clm_latch_measure_bench.sv ----
`timescale 1ns/1ps
module clm_latch_measure_bench;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic [3:0] addr = 4'h0;
	logic [15:0] wdata = 16'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic io_refresh = 1'b0;
	logic [1:0] run = 2'h0;
	logic [3:0] lat = 4'h0;
	logic [15:0] rdata, v0, v1;
	logic [1:0] target_hit, in_range;
	logic [15:0] sent [2];
	clm_pkg::clm_pins_t pins [2];
	int bad_count = 0;
	int checks = 0;
	int cyc = 0;
	int hits0 = 0;
	int hits1 = 0;
	always #12.5 clock = ~clock;
	clm_enc_model enc (.clock(clock), .run(run), .lat(lat),
		.pins(pins), .sent(sent));
	clm_latch_measure #(.SAMPLE_CYC(20), .FREQ_CYC(100)) DUT (
		.clock(clock), .rst(rst), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .pins(pins),
		.target_hit(target_hit), .in_range(in_range),
		.io_refresh(io_refresh));
	task automatic close_out;
		$display("checks=%0d bad_count=%0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Hang guard, well above the expected run
	always @(posedge clock) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			close_out;
		end
	end
	// Count match pulses; each one stands a single cycle
	always @(posedge clock) begin
		if (target_hit[0])
			hits0++;
		if (target_hit[1])
			hits1++;
	end
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		checks++;
		if (s !== e) begin
			bad_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	// Strobe stays up; the next rreg or idle drops it
	task automatic wreg(input logic [3:0] a, input logic [15:0] d);
		wr <= 1'b1;
		rd <= 1'b0;
		addr <= a;
		wdata <= d;
		@(posedge clock);
	endtask
	task automatic rreg(input logic [3:0] a, input logic [15:0] m,
			input logic [15:0] e);
		wr <= 1'b0;
		rd <= 1'b1;
		addr <= a;
		@(posedge clock);
		rd <= 1'b0;
		#1 chk(rdata & m, e);
	endtask
	task automatic idle(input int n);
		wr <= 1'b0;
		rd <= 1'b0;
		repeat (n) @(posedge clock);
	endtask
	task automatic pulses(input int n);
		run <= 2'h3;
		idle(80 * n);
		run <= 2'h0;
		idle(200);
	endtask
	task automatic latch(input logic [3:0] p);
		lat <= p;
		idle(4);
		lat <= 4'h0;
		idle(4);
	endtask
	task automatic refresh;
		io_refresh <= 1'b1;
		idle(1);
		io_refresh <= 1'b0;
		idle(2);
	endtask
	initial begin
		idle(2);
		rst <= 1'b0;
		rreg(4'h2, 16'hffff, 16'h0000);
		// Fast up/down counting, target of three
		wreg(4'h4, 16'h0003);
		rreg(4'h4, 16'h003f, 16'h0003);
		wreg(4'h5, 16'h0003);
		wreg(4'he, 16'h0003);
		wreg(4'hf, 16'h0000);
		wreg(4'h2, 16'h0101);
		rreg(4'h2, 16'hffff, 16'h0101);
		wreg(4'h3, 16'h0201);
		rreg(4'h3, 16'hffff, 16'h0201);
		pulses(4);
		latch(4'h9);
		v0 = sent[0];
		v1 = sent[1];
		rreg(4'h0, 16'h0100, 16'h0000);
		refresh;
		rreg(4'h0, 16'h0100, 16'h0100);
		rreg(4'h1, 16'h0100, 16'h0100);
		rreg(4'h6, 16'hffff, v0);
		rreg(4'h8, 16'hffff, v1);
		$display("test capture done");
		wreg(4'h2, 16'h0301);
		pulses(2);
		latch(4'h6);
		rreg(4'h6, 16'hffff, v0);
		rreg(4'h8, 16'hffff, v1);
		latch(4'h9);
		rreg(4'h6, 16'hffff, sent[0]);
		rreg(4'h8, 16'hffff, sent[1]);
		$display("test overwrite done");
		wreg(4'h2, 16'h0201);
		rreg(4'h0, 16'h0100, 16'h0000);
		// Spacing before switching inputs
		idle(1);
		pulses(1);
		latch(4'h2);
		refresh;
		rreg(4'h0, 16'h0100, 16'h0100);
		rreg(4'h6, 16'hffff, sent[0]);
		$display("test input two done");
		// Software reset while measuring: movement goes negative
		wreg(4'h2, 16'h0207);
		idle(20);
		v0 = 16'h0 - sent[0];
		rreg(4'ha, 16'hffff, v0);
		rreg(4'hb, 16'hffff, 16'hffff);
		$display("test movement done");
		wreg(4'h2, 16'h0205);
		wreg(4'h3, 16'h0205);
		idle(4);
		rreg(4'h0, 16'h0040, 16'h0040);
		rreg(4'h1, 16'h0040, 16'h0040);
		$display("test measure done");
		// Counters passed the target of three once each
		chk(16'(hits0), 16'h0001);
		chk(16'(hits1), 16'h0001);
		// Range check on counter two, value seven within limits
		wreg(4'h5, 16'h0023);
		idle(3);
		chk({14'h0, in_range}, 16'h0002);
		$display("test compare done");
		close_out;
	end
endmodule // clm_latch_measure_bench
